//--- design/otp_regs.svh
`ifndef OTP_REGS_SVH
`define OTP_REGS_SVH

`define OTP_ADDR_W 13
`define OTP_HI_W 5
`define OTP_LO_W 8
`define OTP_DATA_W 8
`define OTP_GND_W 3
`define OTP_MEM_DEPTH 8192
`define OTP_ERASED 8'hFF

`define OTP_LOCK_W 2
`define OTP_LOCK_OPEN 2'b11
`define OTP_LOCK_PAD 6'h3F
`define OTP_VER_SEL_W 2

`define OTP_CNT_W 16

`define OTP_WB_AW 8
`define OTP_REG_CTRL 8'h00
`define OTP_REG_STATUS 8'h04
`define OTP_REG_PCNT 8'h08
`define OTP_REG_SWADDR 8'h0C
`define OTP_REG_SWDATA 8'h10

`define OTP_CTRL_EN_BIT 0
`define OTP_CTRL_RST 1'b1
`define OTP_ST_ENTRY_BIT 0
`define OTP_ST_READY_BIT 1
`define OTP_ST_MODE_LSB 2
`define OTP_ST_LOCK_LSB 4
`define OTP_ST_LOCKOUT_BIT 6

`endif

//--- design/otp_pkg.sv
`include "otp_regs.svh"

package otp_pkg;

    typedef enum logic [1:0] {
        OTP_ACC_RSVD = 2'b00,
        OTP_ACC_VERSION = 2'b01,
        OTP_ACC_LOCK = 2'b10,
        OTP_ACC_MEM = 2'b11
    } otp_acc_type;

    typedef enum logic [1:0] {
        OTP_ST_OFF,
        OTP_ST_ENTRY,
        OTP_ST_READY
    } otp_state_type;

    typedef struct packed {
        otp_state_type st;
        otp_acc_type mode;
        logic [`OTP_HI_W-1:0] hi_addr;
        logic [`OTP_LOCK_W-1:0] lock;
        logic lockout;
        logic port_en;
        logic [`OTP_ADDR_W-1:0] sw_addr;
        logic [`OTP_CNT_W-1:0] write_strobe_n_cnt;
        logic [`OTP_DATA_W-1:0] dout;
        logic bsel_p;
        logic hal_p;
        logic wr_p;
        logic mem_wr;
        logic [`OTP_ADDR_W-1:0] mem_wr_addr;
        logic [`OTP_DATA_W-1:0] mem_wr_data;
        logic ack;
        logic [31:0] wb_dat;
    } otp_state_q_type;

endpackage

//--- design/otp_sync.sv
`timescale 1ns/1ps

module otp_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule

//--- design/otp_write_strobe_n_port.sv
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// What this block does
// - Selector: 00 reserved, 01 version, 10 lock, 11 memory
// - Selector sampled at latch strobe rising edge
// - Upper address captured at latch strobe fall
// - Address port carries A8-A12 then A0-A7
// - Data port reads only under read strobe
// - Programming and lock writes only under write strobe
// - Data port bidirectional, device drives reads except in reserved mode
// - Basic mode entry precedes any access mode
// - Select fall latches strobe roles, stays low

module otp_write_strobe_n_port
    import otp_pkg::*;
#(
    // Arbitrary value, no real part identity
    parameter logic [31:0] VERSION_WORD = 32'h0000_0000
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin,
    input wire logic i_program_store_en_n,
    input wire logic i_basic_sel_n,
    input wire logic i_access_sel_lo,
    input wire logic i_access_sel_hi,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_high_addr_latch,
    input wire logic i_ext_access_vprog,
    input wire logic i_vprog_high,
    input wire logic [`OTP_GND_W-1:0] i_ground_sel,
    input wire logic [`OTP_LO_W-1:0] i_mux_addr_port,
    input wire logic [`OTP_DATA_W-1:0] i_data_port,
    output logic [`OTP_DATA_W-1:0] o_data_port,
    output logic o_data_port_oe,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [`OTP_WB_AW-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);

    localparam int SYNC_W = 10 + `OTP_GND_W + `OTP_LO_W + `OTP_DATA_W;

    otp_state_q_type s_q;
    otp_state_q_type s_d;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;

    logic reset_pin_s;
    logic program_store_en_n_n_s;
    logic bsel_n_s;
    logic sel_lo_s;
    logic sel_hi_s;
    logic rd_n_s;
    logic wr_n_s;
    logic hal_s;
    logic ea_s;
    logic vpp_s;
    logic [`OTP_GND_W-1:0] gnd_s;
    logic [`OTP_LO_W-1:0] addr_s;
    logic [`OTP_DATA_W-1:0] din_s;

    // Erased cells read as ones; the array has no logic reset
    logic [`OTP_DATA_W-1:0] mem [`OTP_MEM_DEPTH] = '{default: `OTP_ERASED};
    logic [`OTP_DATA_W-1:0] mem_pin_rd;
    logic [`OTP_DATA_W-1:0] mem_sw_rd;
    logic [`OTP_ADDR_W-1:0] pin_addr;

    logic static_ok;
    logic bsel_fall;
    logic hal_rise;
    logic hal_fall;
    logic wr_fall;
    logic ready;
    logic lock_open;
    logic wb_req;
    logic [31:0] status_word;

    // Pins come from the programmer's domain
    assign pins_raw = {i_reset_pin, i_program_store_en_n, i_basic_sel_n,
                       i_access_sel_lo, i_access_sel_hi, i_read_strobe_n,
                       i_write_strobe_n, i_high_addr_latch, i_ext_access_vprog,
                       i_vprog_high, i_ground_sel, i_mux_addr_port, i_data_port};

    otp_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    assign {reset_pin_s, program_store_en_n_n_s, bsel_n_s, sel_lo_s, sel_hi_s, rd_n_s,
            wr_n_s, hal_s, ea_s, vpp_s, gnd_s, addr_s, din_s} = pins_s;

    // Full address: latched page plus live low byte
    assign pin_addr = {s_q.hi_addr, addr_s};
    assign mem_pin_rd = mem[pin_addr];
    assign mem_sw_rd = mem[s_q.sw_addr];

    // Static mode conditions; any slip drops the mode
    assign static_ok = reset_pin_s && !program_store_en_n_n_s
                       && (gnd_s == '0)
                       && s_q.port_en && !s_q.lockout;

    assign bsel_fall = s_q.bsel_p && !bsel_n_s;
    assign hal_rise = !s_q.hal_p && hal_s;
    assign hal_fall = s_q.hal_p && !hal_s;
    assign wr_fall = s_q.wr_p && !wr_n_s;
    assign ready = (s_q.st == OTP_ST_READY);
    assign lock_open = (s_q.lock == `OTP_LOCK_OPEN);
    assign wb_req = i_wb_cyc && i_wb_stb && !s_q.ack;

    assign status_word = {25'h0, s_q.lockout, s_q.lock, s_q.mode,
                          (s_q.st == OTP_ST_READY), (s_q.st == OTP_ST_ENTRY)};

    always_comb
    begin
        s_d = s_q;
        s_d.bsel_p = bsel_n_s;
        s_d.hal_p = hal_s;
        s_d.wr_p = wr_n_s;
        s_d.mem_wr = 1'b0;
        s_d.ack = 1'b0;

        unique case (s_q.st)
            OTP_ST_OFF:
            begin
                // Strobe roles latched at the select fall
                if (static_ok && bsel_fall && !wr_n_s && !ea_s && rd_n_s)
                begin
                    s_d.st = OTP_ST_ENTRY;
                    s_d.mode = OTP_ACC_RSVD;
                end
            end
            OTP_ST_ENTRY:
            begin
                if (!static_ok || bsel_n_s)
                begin
                    s_d.st = OTP_ST_OFF;
                end
                else if (wr_n_s)
                begin
                    s_d.st = OTP_ST_READY;
                end
            end
            OTP_ST_READY:
            begin
                if (!static_ok || bsel_n_s)
                begin
                    s_d.st = OTP_ST_OFF;
                    // Protected part cannot be entered again
                    if (!lock_open)
                    begin
                        s_d.lockout = 1'b1;
                    end
                end
            end
            default:
            begin
                s_d.st = OTP_ST_OFF;
            end
        endcase

        if (ready)
        begin
            if (hal_rise)
            begin
                s_d.mode = otp_acc_type'({sel_hi_s, sel_lo_s});
            end
            if (hal_fall)
            begin
                s_d.hi_addr = addr_s[`OTP_HI_W-1:0];
            end
            // Programming needs the high voltage present
            if (wr_fall && rd_n_s && vpp_s)
            begin
                if (s_q.mode == OTP_ACC_MEM && lock_open)
                begin
                    s_d.mem_wr = 1'b1;
                    s_d.mem_wr_addr = pin_addr;
                    s_d.mem_wr_data = din_s;
                    s_d.write_strobe_n_cnt = s_q.write_strobe_n_cnt + 1'b1;
                end
                else if (s_q.mode == OTP_ACC_LOCK)
                begin
                    // Lock bits only ever move towards protection
                    s_d.lock = s_q.lock & din_s[`OTP_LOCK_W-1:0];
                end
            end
        end

        // Read data refreshed every cycle of an active read, except in reserved mode where it holds
        if (ready && !rd_n_s)
        begin
            unique case (s_q.mode)
                OTP_ACC_MEM:
                begin
                    s_d.dout = s_q.lock[1] ? mem_pin_rd : `OTP_ERASED;
                end
                OTP_ACC_LOCK:
                begin
                    s_d.dout = {`OTP_LOCK_PAD, s_q.lock};
                end
                OTP_ACC_VERSION:
                begin
                    s_d.dout = VERSION_WORD[
                        {addr_s[`OTP_VER_SEL_W-1:0], 3'b000} +: `OTP_DATA_W];
                end
                OTP_ACC_RSVD:
                begin
                    s_d.dout = s_q.dout;
                end
            endcase
        end

        // Wishbone slave, answers one cycle after request
        if (wb_req)
        begin
            s_d.ack = 1'b1;
            s_d.wb_dat = 32'h0000_0000;
            unique case (i_wb_adr)
                `OTP_REG_CTRL:
                begin
                    s_d.wb_dat[`OTP_CTRL_EN_BIT] = s_q.port_en;
                    if (i_wb_we && i_wb_sel[0])
                    begin
                        s_d.port_en = i_wb_dat[`OTP_CTRL_EN_BIT];
                    end
                end
                `OTP_REG_STATUS:
                begin
                    s_d.wb_dat = status_word;
                end
                `OTP_REG_PCNT:
                begin
                    s_d.wb_dat = {16'h0000, s_q.write_strobe_n_cnt};
                    if (i_wb_we && i_wb_sel[0])
                    begin
                        // A byte programmed in the clear cycle still counts
                        s_d.write_strobe_n_cnt = `OTP_CNT_W'(s_d.mem_wr);
                    end
                end
                `OTP_REG_SWADDR:
                begin
                    s_d.wb_dat = {19'h0, s_q.sw_addr};
                    if (i_wb_we && (&i_wb_sel[1:0]))
                    begin
                        s_d.sw_addr = i_wb_dat[`OTP_ADDR_W-1:0];
                    end
                end
                `OTP_REG_SWDATA:
                begin
                    s_d.wb_dat = {24'h0, mem_sw_rd};
                end
                default:
                begin
                    s_d.wb_dat = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_q.st <= OTP_ST_OFF;
            s_q.mode <= OTP_ACC_RSVD;
            s_q.hi_addr <= '0;
            s_q.lock <= `OTP_LOCK_OPEN;
            s_q.lockout <= 1'b0;
            s_q.port_en <= `OTP_CTRL_RST;
            s_q.sw_addr <= '0;
            s_q.write_strobe_n_cnt <= '0;
            s_q.dout <= '0;
            s_q.bsel_p <= 1'b1;
            s_q.hal_p <= 1'b0;
            s_q.wr_p <= 1'b0;
            s_q.mem_wr <= 1'b0;
            s_q.mem_wr_addr <= '0;
            s_q.mem_wr_data <= '0;
            s_q.ack <= 1'b0;
            s_q.wb_dat <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // One-time cells: programming only clears bits
    always_ff @(posedge i_clk)
    begin
        if (s_q.mem_wr)
        begin
            mem[s_q.mem_wr_addr] <= mem[s_q.mem_wr_addr] & s_q.mem_wr_data;
        end
    end

    // Drive ends with the synchronised strobe, two cycles late
    assign o_data_port_oe = ready && !rd_n_s && (s_q.mode != OTP_ACC_RSVD);
    assign o_data_port = s_q.dout;
    assign o_wb_dat = s_q.wb_dat;
    assign o_wb_ack = s_q.ack;

endmodule

//--- testbench/otp_write_strobe_n_port_asserts.sv
`timescale 1ns/1ps
module otp_write_strobe_n_port_asserts
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_read_strobe_n,
    input wire logic o_data_port_oe,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire hole = !(i_wb_adr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
    sequence s_rd_release;
        $rose(i_read_strobe_n) ##1 i_read_strobe_n [*2];
    endsequence
    sequence s_take;
        req && !i_wb_we && hole;
    endsequence
    property p_oe_cause;
        o_data_port_oe |-> !$past(i_read_strobe_n, 2);
    endproperty
    property p_oe_idle;
        i_read_strobe_n [*3] |-> !o_data_port_oe;
    endproperty
    property p_oe_release;
        s_rd_release |=> !o_data_port_oe;
    endproperty
    property p_ack_answer;
        req |=> o_wb_ack;
    endproperty
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    property p_ack_cause;
        o_wb_ack |-> $past(req);
    endproperty
    property p_hole_zero;
        s_take |=> o_wb_dat == 32'h0;
    endproperty
    property p_reset_quiet;
        $rose(i_rst_n) |-> !o_wb_ack && !o_data_port_oe && o_wb_dat == 32'h0;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe without read");
    a_oe_idle: assert property (p_oe_idle) else $error("oe while idle");
    a_oe_release: assert property (p_oe_release) else $error("oe held");
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_hole_zero: assert property (p_hole_zero) else $error("hole data");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs");
endmodule
bind otp_write_strobe_n_port otp_write_strobe_n_port_asserts otp_write_strobe_n_port_asserts_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_read_strobe_n(i_read_strobe_n), .o_data_port_oe(o_data_port_oe),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));

//--- testbench/otp_prg.sv
`timescale 1ns/1ps
module otp_prg
(
    input wire logic i_clk,
    input wire logic i_dev_oe,
    input wire logic [7:0] i_dev_data,
    output logic [7:0] o_data_bus
);
    logic sel_n = 1'b1;
    logic program_store_en_n_n = 1'b0;
    logic wr_n = 1'b0;
    logic ea = 1'b0;
    logic vph = 1'b0;
    logic latch = 1'b0;
    logic [1:0] acc = 2'h1;
    logic rd_n = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] drv = 8'h00;
    logic drv_en = 1'b0;
    logic [7:0] last_q = 8'h00;
    // Released bus toggles, so stale data never looks valid
    assign o_data_bus = i_dev_oe ? i_dev_data : (drv_en ? drv : ~last_q);
    always_ff @(posedge i_clk)
        last_q <= o_data_bus;
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic enter();
        sel_n <= 1'b0;
        tick(3);
        wr_n <= 1'b1;
        tick(3);
        ea <= 1'b1;
        tick(3);
    endtask
    task automatic leave();
        sel_n <= 1'b1;
        tick(4);
        wr_n <= 1'b0;
        ea <= 1'b0;
        tick(4);
    endtask
    task automatic slip(input int n);
        program_store_en_n_n <= 1'b1;
        tick(n);
        program_store_en_n_n <= 1'b0;
        tick(n);
    endtask
    task automatic pick(input logic [1:0] mode, input logic [4:0] page);
        acc <= mode;
        tick(3);
        latch <= 1'b1;
        addr <= {3'h0, page};
        tick(3);
        latch <= 1'b0;
        tick(3);
    endtask
    task automatic put(input logic [7:0] lo, input logic [7:0] data);
        addr <= lo;
        drv <= data;
        drv_en <= 1'b1;
        vph <= 1'b1;
        tick(3);
        wr_n <= 1'b0;
        tick(4);
        wr_n <= 1'b1;
        tick(3);
        drv_en <= 1'b0;
        vph <= 1'b0;
        tick(3);
    endtask
    task automatic get(input logic [7:0] lo, output logic [7:0] data, output logic oe);
        addr <= lo;
        tick(3);
        rd_n <= 1'b0;
        tick(4);
        data = o_data_bus;
        oe = i_dev_oe;
        rd_n <= 1'b1;
        tick(4);
    endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "otp_regs.svh"
module tb
    import otp_pkg::*;
;
    // Arbitrary value
    localparam logic [31:0] VER = 32'h1234_5678;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack;
    wire [7:0] dout;
    wire oe;
    wire [7:0] bus;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 i_clk = ~i_clk;
    otp_prg otp_prg_inst (.i_clk(i_clk), .i_dev_oe(oe), .i_dev_data(dout), .o_data_bus(bus));
    otp_write_strobe_n_port #(.VERSION_WORD(VER)) otp_write_strobe_n_port_inst
    (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_reset_pin(1'b1),
        .i_program_store_en_n(otp_prg_inst.program_store_en_n_n),
        .i_ground_sel(3'h0),
        .i_basic_sel_n(otp_prg_inst.sel_n), .i_write_strobe_n(otp_prg_inst.wr_n),
        .i_access_sel_lo(otp_prg_inst.acc[0]), .i_access_sel_hi(otp_prg_inst.acc[1]),
        .i_read_strobe_n(otp_prg_inst.rd_n), .i_high_addr_latch(otp_prg_inst.latch),
        .i_ext_access_vprog(otp_prg_inst.ea), .i_vprog_high(otp_prg_inst.vph),
        .i_mux_addr_port(otp_prg_inst.addr), .i_data_port(bus),
        .o_data_port(dout), .o_data_port_oe(oe),
        .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack)
    );
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_clk);
        while (ack !== 1'b1)
        begin
            @(posedge i_clk);
        end
        q = rdat;
        cyc <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        cmp(name, exp, q);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        rd(`OTP_REG_CTRL, 32'h1, "ctrl");
        rd(`OTP_REG_STATUS, 32'h30, "status");
        wb(1'b1, 8'h14, 32'hFFFF_FFFF, q);
        rd(8'h14, 32'h0, "unmapped");
        rd(`OTP_REG_CTRL, 32'h1, "ctrl kept");
    endtask
    task automatic t_mem();
        logic [7:0] d;
        logic e;
        logic [31:0] q;
        otp_prg_inst.enter();
        wb(1'b0, `OTP_REG_STATUS, 32'h0, q);
        cmp("ready", 32'h32, q & 32'h7E);
        otp_prg_inst.pick(OTP_ACC_MEM, 5'h15);
        wb(1'b0, `OTP_REG_STATUS, 32'h0, q);
        cmp("mem mode", 32'h3E, q & 32'h7E);
        otp_prg_inst.put(8'hA5, 8'h3C);
        otp_prg_inst.acc <= OTP_ACC_VERSION;
        otp_prg_inst.get(8'hA5, d, e);
        cmp("mem byte", 32'h3C, {24'h0, d});
        cmp("read drive", 32'h1, {31'h0, e});
        otp_prg_inst.get(8'hA6, d, e);
        cmp("erased", 32'hFF, {24'h0, d});
        rd(`OTP_REG_PCNT, 32'h1, "count");
        wb(1'b1, `OTP_REG_PCNT, 32'h0, q);
        rd(`OTP_REG_PCNT, 32'h0, "count clear");
        wb(1'b1, `OTP_REG_SWADDR, 32'h15A5, q);
        rd(`OTP_REG_SWDATA, 32'h3C, "sw data");
    endtask
    task automatic t_modes();
        logic [7:0] d;
        logic e;
        otp_prg_inst.pick(OTP_ACC_VERSION, 5'h00);
        for (int i = 0; i < 4; i++)
        begin
            otp_prg_inst.get(8'(i), d, e);
            cmp("version", {24'h0, VER[8*i +: 8]}, {24'h0, d});
        end
        otp_prg_inst.pick(OTP_ACC_RSVD, 5'h00);
        otp_prg_inst.get(8'h00, d, e);
        cmp("reserved oe", 32'h0, {31'h0, e});
        otp_prg_inst.pick(OTP_ACC_LOCK, 5'h00);
        otp_prg_inst.put(8'h00, 8'hFE);
        otp_prg_inst.get(8'h00, d, e);
        cmp("lock bits", 32'hFE, {24'h0, d});
    endtask
    task automatic t_lockout();
        logic [31:0] q;
        otp_prg_inst.leave();
        rd(`OTP_REG_STATUS, 32'h68, "lockout");
        otp_prg_inst.enter();
        wb(1'b0, `OTP_REG_STATUS, 32'h0, q);
        cmp("entry refused", 32'h40, q & 32'h43);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(`OTP_REG_STATUS, 32'h30, "after reset");
        otp_prg_inst.leave();
        otp_prg_inst.enter();
        wb(1'b0, `OTP_REG_STATUS, 32'h0, q);
        cmp("re-entry", 32'h2, q & 32'h43);
        otp_prg_inst.slip(4);
        wb(1'b0, `OTP_REG_STATUS, 32'h0, q);
        cmp("static slip", 32'h0, q & 32'h43);
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_regs();
        t_mem();
        t_modes();
        t_lockout();
        t_reset();
        complete_run();
    end
endmodule
